// >>> core/drmc_params.svh
// timing, geometry and refresh constants for the 1k x 1 dram controller
// assumes a 10 MHz mclk and an external dram driven straight from flops
// Function
// - refresh means 32 reads covering every value of address bits 4..0
// - standard grade: complete all refresh reads within every 2 ms
// - fast grade: every row refreshed at least once per millisecond
// - one cycle strobe times each access; no precharge clock exists
// - read, write and read-then-write cycles chosen by read/write select
`ifndef DRMC_PARAMS_SVH
`define DRMC_PARAMS_SVH

`define DRMC_CLK_NS 100
`define DRMC_ADDR_W 10
`define DRMC_ROW_W 5
`define DRMC_ROWS 32
// refresh interval, microseconds, per grade
`define DRMC_TREF_STD_US 2000
`define DRMC_TREF_FAST_US 1000
// strobe timing in ns (slow grade figures cover both grades)
`define DRMC_T_AC_NS 30
`define DRMC_T_CV_NS 210
`define DRMC_T_CO_NS 185
`define DRMC_T_CC_NS 230
`define DRMC_T_WP_NS 50
`define DRMC_T_DH_NS 10
// least and longest times both round up to whole cycles
`define DRMC_UP(ns) (((ns) + `DRMC_CLK_NS - 1) / `DRMC_CLK_NS)
`define DRMC_AC_CYC `DRMC_UP(`DRMC_T_AC_NS)
`define DRMC_CV_CYC `DRMC_UP(`DRMC_T_CV_NS)
`define DRMC_CO_CYC `DRMC_UP(`DRMC_T_CO_NS)
`define DRMC_CC_CYC `DRMC_UP(`DRMC_T_CC_NS)
`define DRMC_WP_CYC `DRMC_UP(`DRMC_T_WP_NS)
`define DRMC_DH_CYC `DRMC_UP(`DRMC_T_DH_NS)
// per-row refresh spacing: interval / rows, rounded down
`define DRMC_RSTEP(us) (((us) * 1000) / (`DRMC_ROWS * `DRMC_CLK_NS))
`define DRMC_RSTEP_STD `DRMC_RSTEP(`DRMC_TREF_STD_US)
`define DRMC_RSTEP_FAST `DRMC_RSTEP(`DRMC_TREF_FAST_US)

`endif

// >>> core/drmc_pkg.sv
// types shared by the dram controller
// assumes drmc_params.svh is included by the design
package drmc_pkg;
	typedef enum logic [1:0] {
		DRMC_OP_READ,
		DRMC_OP_WRITE,
		DRMC_OP_RMW
	} drmc_op_t;
	typedef enum logic [2:0] {
		DRMC_IDLE,
		DRMC_SETUP,
		DRMC_ON,
		DRMC_WPULSE,
		DRMC_HOLD,
		DRMC_OFF
	} drmc_state_t;
endpackage

// >>> core/drmc_ctrl.sv
// controller for a 1k x 1 dynamic ram with one cycle strobe
// assumes the dram pins are wired straight to the outputs; dout is async
`timescale 1ns/1ps
`include "drmc_params.svh"
module drmc_ctrl
	import drmc_pkg::*;
#(
	parameter int REF_STEP_STD = `DRMC_RSTEP_STD,
	parameter int REF_STEP_FAST = `DRMC_RSTEP_FAST
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fast_grade,
	input wire logic req_valid,
	input wire drmc_op_t req_op,
	input wire logic [`DRMC_ADDR_W-1:0] req_addr,
	input wire logic req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic rsp_rdata,
	output logic ram_strobe_n,
	output logic ram_write_n,
	output logic [`DRMC_ADDR_W-1:0] ram_addr,
	output logic ram_din,
	input wire logic ram_dout
);
	// longest access, take edge to the return to idle, in cycles
	localparam int LONG_CYC = `DRMC_AC_CYC + `DRMC_CV_CYC + `DRMC_WP_CYC +
		`DRMC_DH_CYC + `DRMC_CC_CYC;

	////////////////////////////////////////////////////////////////////
	// elaboration checks; a step not above the longest access could let
	// two ticks merge while one access runs, and one refresh would be lost
	initial begin
		if (REF_STEP_FAST <= LONG_CYC || REF_STEP_STD < REF_STEP_FAST ||
		    REF_STEP_STD > 65535)
			$error("drmc_ctrl: refresh step out of range");
		// read data is taken one cycle before the on time ends
		if (`DRMC_CV_CYC - 1 < `DRMC_CO_CYC || `DRMC_CC_CYC > 15)
			$error("drmc_ctrl: strobe timing does not fit the timer");
	end

	////////////////////////////////////////////////////////////////////
	// dram output pin synchroniser; first stage feeds only the second
	logic dout_s1_reg;
	logic dout_s2_reg;
	always_ff @(posedge mclk) begin
		dout_s1_reg <= ram_dout;
		dout_s2_reg <= dout_s1_reg;
	end

	////////////////////////////////////////////////////////////////////
	// refresh timer: one row due every step; grade picks the step
	logic [15:0] ref_cnt_reg;
	logic ref_due_reg;
	logic [`DRMC_ROW_W-1:0] row_reg;
	logic ref_take;
	logic [15:0] step;
	logic ref_tick;
	assign step = fast_grade ? 16'(REF_STEP_FAST) : 16'(REF_STEP_STD);
	// one tick per step; shared by the counter and the pending flag
	assign ref_tick = ref_cnt_reg >= step - 16'h0001;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ref_cnt_reg <= 16'h0000;
		end else if (ref_tick) begin
			ref_cnt_reg <= 16'h0000;
		end else begin
			ref_cnt_reg <= ref_cnt_reg + 16'h0001;
		end
	end
	// pending flag: a new tick wins over the take in the same cycle
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ref_due_reg <= 1'b0;
		else if (ref_tick)
			ref_due_reg <= 1'b1;
		else if (ref_take)
			ref_due_reg <= 1'b0;
	end
	// row counter walks all 32 low-address values
	always_ff @(posedge mclk) begin
		if (!rst_n)
			row_reg <= '0;
		else if (ref_take)
			row_reg <= row_reg + 5'h01;
	end

	////////////////////////////////////////////////////////////////////
	// access sequencer; one strobe per cycle, no precharge
	drmc_state_t state_reg;
	logic [3:0] tmr_reg;
	logic is_ref_reg;
	drmc_op_t op_reg;
	logic wdata_reg;
	logic start;
	assign start = (state_reg == DRMC_IDLE) && (ref_due_reg || req_valid);
	// refresh is taken ahead of a waiting request
	assign ref_take = start && ref_due_reg;
	// last cycle of the strobe-on time; the sequencer and response share it
	function automatic logic on_last(drmc_state_t s, logic [3:0] t);
		return s == DRMC_ON && t <= 4'h1;
	endfunction

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= DRMC_IDLE;
			tmr_reg <= 4'h0;
		end else begin
			case (state_reg)
				DRMC_IDLE: begin
					if (start) begin
						state_reg <= DRMC_SETUP;
						tmr_reg <= 4'(`DRMC_AC_CYC);
					end
				end
				DRMC_SETUP: begin
					if (tmr_reg <= 4'h1) begin
						state_reg <= DRMC_ON;
						tmr_reg <= 4'(`DRMC_CV_CYC);
					end else
						tmr_reg <= tmr_reg - 4'h1;
				end
				DRMC_ON: begin
					// strobe low for the on time; output settles and is
					// sampled one cycle before the last on cycle
					if (on_last(state_reg, tmr_reg)) begin
						if (!is_ref_reg && op_reg != DRMC_OP_READ) begin
							state_reg <= DRMC_WPULSE;
							tmr_reg <= 4'(`DRMC_WP_CYC);
						end else begin
							state_reg <= DRMC_OFF;
							tmr_reg <= 4'(`DRMC_CC_CYC);
						end
					end else
						tmr_reg <= tmr_reg - 4'h1;
				end
				DRMC_WPULSE: begin
					// one-cycle write pulse with the strobe still low
					if (tmr_reg <= 4'h1) begin
						state_reg <= DRMC_HOLD;
						tmr_reg <= 4'(`DRMC_DH_CYC);
					end else
						tmr_reg <= tmr_reg - 4'h1;
				end
				DRMC_HOLD: begin
					// strobe and write rise together; din stays driven
					if (tmr_reg <= 4'h1) begin
						state_reg <= DRMC_OFF;
						tmr_reg <= 4'(`DRMC_CC_CYC);
					end else
						tmr_reg <= tmr_reg - 4'h1;
				end
				DRMC_OFF: begin
					if (tmr_reg <= 4'h1)
						state_reg <= DRMC_IDLE;
					else
						tmr_reg <= tmr_reg - 4'h1;
				end
				default: state_reg <= DRMC_IDLE;
			endcase
		end
	end

	// capture request at start; address held for the whole cycle
	// wdata stays until the next take, which covers the data hold
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			is_ref_reg <= 1'b0;
			op_reg <= DRMC_OP_READ;
			wdata_reg <= 1'b0;
			ram_addr <= '0;
		end else if (start) begin
			is_ref_reg <= ref_due_reg;
			op_reg <= ref_due_reg ? DRMC_OP_READ : req_op;
			wdata_reg <= req_wdata;
			// refresh puts the row on the low five bits and drives the upper five to zero
			ram_addr <= ref_due_reg ? {5'h00, row_reg} : req_addr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin drive: strobe is the sole timing signal
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ram_strobe_n <= 1'b1;
			ram_write_n <= 1'b1;
			ram_din <= 1'b0;
		end else begin
			// strobe high in idle and off keeps the ram in standby
			ram_strobe_n <= !(state_reg == DRMC_SETUP ||
			                  state_reg == DRMC_ON ||
			                  state_reg == DRMC_WPULSE);
			// write pulse only inside the strobe
			ram_write_n <= !(state_reg == DRMC_WPULSE);
			ram_din <= wdata_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// response: read data is taken one cycle after the on time's last
	// cycle, so the synchroniser hands over the pin as it stood two cycles
	// before the strobe's end, past the output delay; earlier is stale
	logic rsp_pend_reg;
	always_ff @(posedge mclk) begin
		if (!rst_n)
			rsp_pend_reg <= 1'b0;
		else
			rsp_pend_reg <= on_last(state_reg, tmr_reg) && !is_ref_reg &&
				op_reg != DRMC_OP_WRITE;
	end
	// handshake pulses and read data
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 1'b0;
		end else begin
			req_ready <= start && !ref_due_reg;
			rsp_valid <= rsp_pend_reg;
			if (rsp_pend_reg)
				rsp_rdata <= dout_s2_reg;
		end
	end
endmodule

// >>> dv/drmc_ram_model.sv
// behavioural 1k x 1 dram with one cycle strobe
// assumes pins wired straight from drmc_ctrl
`timescale 1ns/1ps
`include "drmc_params.svh"
module drmc_ram_model (
	input wire logic ram_strobe_n,
	input wire logic ram_write_n,
	input wire logic [9:0] ram_addr,
	input wire logic ram_din,
	output logic ram_dout
);
	logic mem [1024];
	logic [9:0] lat_reg = 10'h000;
	logic vld_reg = 1'b0;
	logic wr_pend = 1'b0;
	initial foreach (mem[i]) mem[i] = 1'b0;
	// address latched as the strobe falls, so the pins may move later;
	// data shows only after the output delay, garbage before it
	always begin
		@(negedge ram_strobe_n);
		lat_reg = ram_addr;
		#(`DRMC_T_CO_NS);
		vld_reg = !ram_strobe_n;
		if (!ram_strobe_n)
			@(posedge ram_strobe_n);
		vld_reg = 1'b0;
	end
	// a write pulse inside the strobe lands as write or strobe rises,
	// whichever comes first; reads never touch the array
	always @(ram_write_n or ram_strobe_n) begin
		if (!ram_write_n && !ram_strobe_n)
			wr_pend = 1'b1;
		else if (wr_pend) begin
			mem[lat_reg] = ram_din;
			wr_pend = 1'b0;
		end
	end
	// standby: output released, shows the inverse so stale data cannot pass
	assign ram_dout = vld_reg ? mem[lat_reg] : ~mem[lat_reg];
endmodule

// >>> dv/drmc_ctrl_checker.sv
// pin-level assertions for the dram controller
// assumes bind to drmc_ctrl with its refresh steps handed on
`timescale 1ns/1ps
module drmc_ctrl_checker
	import drmc_pkg::*;
#(
	parameter int REF_STEP_STD = 625,
	parameter int REF_STEP_FAST = 312
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fast_grade,
	input wire drmc_op_t req_op,
	input wire logic [9:0] req_addr,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic ram_strobe_n,
	input wire logic ram_write_n,
	input wire logic [9:0] ram_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic stb_reg, rdy_reg, seen_reg, ref_fall;
	logic [11:0] gap_reg;
	logic [4:0] row_reg;
	// a strobe fall not led by an accept the cycle before is a refresh
	assign ref_fall = stb_reg && !ram_strobe_n && !rdy_reg;
	// cycles since last refresh and last row refreshed
	always_ff @(posedge mclk) begin
		stb_reg <= ram_strobe_n;
		rdy_reg <= req_ready;
		gap_reg <= (!rst_n || ref_fall) ? 12'h000 : gap_reg + 12'h001;
		seen_reg <= rst_n && (seen_reg || ref_fall);
		if (ref_fall)
			row_reg <= ram_addr[4:0];
	end
	sequence s_read;
		##1 (!ram_strobe_n && ram_write_n) [*4] ##1 ram_strobe_n;
	endsequence
	sequence s_write;
		##5 !ram_write_n && !ram_strobe_n ##1 ram_write_n && ram_strobe_n;
	endsequence
	////////////////////////////////////////////////////////////////////
	AST_TAKE: assert property (req_ready |-> ram_addr == req_addr ##1
		$fell(ram_strobe_n)) else $error("bad strobe at accept");
	AST_READY: assert property (req_ready |=> !req_ready)
		else $error("accept pulse too long");
	AST_READ: assert property (req_ready && req_op == DRMC_OP_READ |->
		s_read) else $error("bad read cycle");
	AST_WRITE: assert property (req_ready && req_op != DRMC_OP_READ |->
		s_write) else $error("bad write pulse");
	AST_RSP: assert property (req_ready && req_op != DRMC_OP_WRITE |->
		##5 rsp_valid ##1 !rsp_valid) else $error("bad response");
	AST_WIDTH: assert property ($fell(ram_strobe_n) |->
		!ram_strobe_n [*3]) else $error("strobe too short");
	AST_ADDR: assert property (!ram_strobe_n && !$past(ram_strobe_n) |->
		$stable(ram_addr)) else $error("address moved");
	AST_GAP: assert property (gap_reg <= (fast_grade ? REF_STEP_FAST :
		REF_STEP_STD) + 12) else $error("refresh late");
	AST_ROW: assert property (ref_fall && seen_reg |->
		ram_addr == {5'h00, row_reg + 5'h01}) else $error("bad refresh row");
	AST_WRSTB: assert property (!ram_write_n |-> !ram_strobe_n)
		else $error("write pulse outside strobe");
endmodule
bind drmc_ctrl drmc_ctrl_checker #(
	.REF_STEP_STD(REF_STEP_STD),
	.REF_STEP_FAST(REF_STEP_FAST)
) chk (.mclk(mclk), .rst_n(rst_n), .fast_grade(fast_grade),
	.req_op(req_op), .req_addr(req_addr), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .ram_strobe_n(ram_strobe_n),
	.ram_write_n(ram_write_n), .ram_addr(ram_addr));

// >>> dv/drmc_ctrl_bench.sv
// self-checking bench: controller plus behavioural dram
// assumes short refresh steps of 20 and 10 cycles
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module drmc_ctrl_bench
	import drmc_pkg::*;
;
	logic mclk = 1'b0, rst_n = 1'b0, fast_grade = 1'b0, req_valid = 1'b0;
	drmc_op_t req_op = DRMC_OP_READ;
	logic [9:0] req_addr = 10'h000, ram_addr;
	logic req_wdata = 1'b0, req_ready, rsp_valid, rsp_rdata;
	logic ram_strobe_n, ram_write_n, ram_din, ram_dout;
	logic shadow [1024] = '{default: 1'b0};
	logic exp_q [$];
	int errors = 0, checks = 0, seed = 32'h5814;
	drmc_ctrl #(.REF_STEP_STD(20), .REF_STEP_FAST(10)) dut (.mclk(mclk),
		.rst_n(rst_n), .fast_grade(fast_grade), .req_valid(req_valid),
		.req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.ram_strobe_n(ram_strobe_n), .ram_write_n(ram_write_n),
		.ram_addr(ram_addr), .ram_din(ram_din), .ram_dout(ram_dout));
	drmc_ram_model ram (.ram_strobe_n(ram_strobe_n), .ram_write_n(ram_write_n),
		.ram_addr(ram_addr), .ram_din(ram_din), .ram_dout(ram_dout));
	initial forever #50 mclk = ~mclk;
	// each response against the oldest note
	always @(negedge mclk) if (rsp_valid === 1'b1) begin
		`CHK("rdata", exp_q.pop_front(), rsp_rdata)
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one access; held until accepted, then lines scrambled
	task automatic acc(drmc_op_t op, logic [9:0] a);
		logic w;
		int n;
		w = 1'($random(seed));
		n = 0;
		if (op != DRMC_OP_WRITE)
			exp_q.push_back(shadow[a]);
		if (op != DRMC_OP_READ)
			shadow[a] = w;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		req_wdata <= w;
		do begin @(negedge mclk); n++; end while (req_ready !== 1'b1 && n < 200);
		`CHK("ready", 1'b1, req_ready)
		@(posedge mclk);
		req_valid <= 1'b0;
		req_addr <= ~a;
		req_wdata <= ~w;
	endtask
	// second pass resets in mid-run and switches grade
	initial begin
		for (int g = 0; g < 2; g++) begin
			@(posedge mclk);
			rst_n <= 1'b0;
			fast_grade <= g[0];
			repeat (20) @(posedge mclk);
			rst_n <= 1'b1;
			@(negedge mclk);
			`CHK("standby", 1'b1, ram_strobe_n)
			for (int i = 0; i < 60; i++)
				acc(drmc_op_t'(2'({$random(seed)} % 3)),
					10'({$random(seed)} % 6) ^ (i[0] ? 10'h3FF : 10'h000));
			repeat (700) @(posedge mclk);
			`CHK("pending", 0, exp_q.size())
		end
		print_verdict();
	end
	initial begin
		#1000000;
		errors++;
		print_verdict();
	end
endmodule
